// File: dmac_mem.sv
// Operand memory model driving the four MAC data buses
`timescale 1ns/1ps
`default_nettype none
module dmac_mem
   import dmac_pkg::*;
(
   input wire logic sys_clk,
   input wire dmac_addr_s mem_addr,
   output dmac_data_s mem_data
);
   // Small data and coefficient stores, low address bits only
   logic [DATA_W-1:0] dmem [256];
   logic [DATA_W-1:0] cmem [256];
   // Last answer, so a released bus can show its inverse
   dmac_data_s last_q = '0;

   always_comb begin
      if (mem_addr.rd) begin
         mem_data.c_data_bus = dmem[mem_addr.data_hi[7:0]];
         mem_data.d_data_bus = dmem[mem_addr.data_lo[7:0]];
         mem_data.second_b_data_bus = cmem[mem_addr.coef_hi[7:0]];
         mem_data.b_data_bus = cmem[mem_addr.coef_lo[7:0]];
      end else begin
         // Idle buses carry junk, so stale data is never trusted
         mem_data = ~last_q;
      end
   end

   // Remember what was last driven
   always_ff @(posedge sys_clk) begin
      if (mem_addr.rd) begin
         last_q <= mem_data;
      end
   end
endmodule : dmac_mem
`default_nettype wire

// File: dmac_pkg.sv
// Shared constants and types for the dual long-word MAC datapath
// Function
// - Both MAC operations finish in one cycle
// - High halves fetched at EA feed unit two
// - Low halves fetched at EA partner address
// - Fixed routing of halves onto four buses
// - Operands sign-extended to 17 bits by default
// - Unsigned keyword zero-extends operand to 17 bits
// - Fractional mode doubles each product
// - Saturate-on-multiply bit governs product overflow
// - Single shift: Y gets unshifted accumulate
// - Single shift: X shifted right 16 first
// - Double shift: both accumulators shifted first
// - Round keyword rounds per rounding mode
// - Overflow sets destination accumulator flag
// - Saturation enable clamps overflowed accumulator
// - Forty-bit keyword acts for one instruction
// - Instruction may run under single repeat
// - Long-word pointer steps by two
package dmac_pkg;
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int ACC_W = 40;
   localparam int PROD_W = 32;
   localparam int EXT_W = 17;
   localparam int SHIFT_AMT = 16;
   localparam int RND_BITS = 16;
   localparam int RPT_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_ACCX_LO = 8'h0c;
   localparam logic [7:0] OFS_ACCX_HI = 8'h10;
   localparam logic [7:0] OFS_ACCY_LO = 8'h14;
   localparam logic [7:0] OFS_ACCY_HI = 8'h18;
   localparam logic [7:0] OFS_AUX = 8'h1c;
   localparam logic [7:0] OFS_COEF = 8'h20;
   localparam logic [7:0] OFS_BUSY = 8'h24;
   // Control field positions
   localparam int CTRL_FRAC = 0;
   localparam int CTRL_MSAT = 1;
   localparam int CTRL_RMODE = 2;
   localparam int CTRL_SATEN = 3;
   localparam int CTRL_WIDE = 4;
   // Status and mask field positions
   localparam int ST_OVX = 0;
   localparam int ST_OVY = 1;
   localparam int ST_DONE = 2;
   // Reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Arithmetic constants
   localparam logic [ADDR_W-1:0] PTR_STEP = 23'h000002;
   localparam logic [RND_BITS-1:0] RND_HALF = 16'h8000;
   localparam logic [ACC_W:0] RND_ADD = 41'h000_0000_8000;
   localparam logic [ACC_W-1:0] SAT40_POS = 40'h7f_ffff_ffff;
   localparam logic [ACC_W-1:0] SAT40_NEG = 40'h80_0000_0000;
   localparam logic [ACC_W-1:0] SAT32_POS = 40'h00_7fff_ffff;
   localparam logic [ACC_W-1:0] SAT32_NEG = 40'hff_8000_0000;
   localparam logic [DATA_W-1:0] MIN_Q15 = 16'h8000;
   localparam logic [PROD_W-1:0] PROD_MAX = 32'h7fff_ffff;
   // Sequencer states
   typedef enum logic [1:0] {
      DMAC_IDLE = 2'b01,
      DMAC_EXEC = 2'b10
   } dmac_fsm_e;
   // Mode bits set by software
   typedef struct packed {
      logic forty_bit_computation_bit;
      logic saturation_enable_bit;
      logic rounding_mode_bit;
      logic saturate_on_multiply_bit;
      logic fractional_mode_bit;
   } dmac_ctrl_s;
   // One issued instruction
   typedef struct packed {
      logic dbl_shift;
      logic uns_data;
      logic uns_coef;
      logic rnd;
      logic forty_bit_kw;
      logic aux_dec;
      logic coef_inc;
      logic [RPT_W-1:0] repeat_cnt;
   } dmac_issue_s;
   // Operand addresses toward memory
   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] data_hi;
      logic [ADDR_W-1:0] data_lo;
      logic [ADDR_W-1:0] coef_hi;
      logic [ADDR_W-1:0] coef_lo;
   } dmac_addr_s;
   // Operand data from the four buses
   typedef struct packed {
      logic [DATA_W-1:0] c_data_bus;
      logic [DATA_W-1:0] d_data_bus;
      logic [DATA_W-1:0] b_data_bus;
      logic [DATA_W-1:0] second_b_data_bus;
   } dmac_data_s;
   // Whole state of the top module
   typedef struct packed {
      dmac_fsm_e fsm;
      dmac_ctrl_s ctrl;
      logic [2:0] status;
      logic [2:0] mask;
      logic [ACC_W-1:0] acc_x;
      logic [ACC_W-1:0] acc_y;
      logic [ADDR_W-1:0] aux;
      logic [ADDR_W-1:0] coef;
      dmac_issue_s ins;
      logic [RPT_W-1:0] rpt;
      logic [31:0] rdata;
      logic slverr;
      logic done;
   } dmac_state_s;
endpackage : dmac_pkg

// File: dmac_top.sv
// Dual long-word MAC datapath with APB registers
`timescale 1ns/1ps
`default_nettype none
module dmac_top
   import dmac_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic issue_valid,
   input wire dmac_issue_s issue,
   output logic issue_ready,
   output dmac_addr_s mem_addr,
   input wire dmac_data_s mem_data,
   output logic done,
   output logic irq
);
   // Registered state and its next value
   dmac_state_s state_q;
   dmac_state_s state_d;

   // Lane wires
   logic [PROD_W-1:0] prod_y; // Unit two product
   logic [PROD_W-1:0] prod_x; // Unit one product
   logic sat_y; // Unit two clamped
   logic sat_x; // Unit one clamped
   logic [ACC_W-1:0] res_y; // New accumulator y
   logic [ACC_W-1:0] res_x; // New accumulator x
   logic ovf_y; // Lane y overflowed
   logic ovf_x; // Lane x overflowed
   logic forty_bit_eff; // Boundary for this instruction
   logic exec; // A pair runs this cycle

   // APB decode
   logic apb_setup; // Setup phase seen
   logic apb_wr; // Write access edge
   logic map_hit; // Address is mapped
   logic [31:0] rd_mux; // Read value chosen
   logic idle; // Free for writes

   assign exec = (state_q.fsm == DMAC_EXEC);
   assign idle = (state_q.fsm == DMAC_IDLE);
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite;

   assign forty_bit_eff = state_q.ctrl.forty_bit_computation_bit | state_q.ins.forty_bit_kw;

   // low halves at partner
   // Flipping bit 0 gives EA+1 for even, EA-1 for odd
   always_comb begin
      mem_addr.rd = exec;
      mem_addr.data_hi = state_q.aux;
      mem_addr.data_lo = {state_q.aux[ADDR_W-1:1], ~state_q.aux[0]};
      mem_addr.coef_hi = state_q.coef;
      mem_addr.coef_lo = {state_q.coef[ADDR_W-1:1], ~state_q.coef[0]};
   end

   // high pair from c and b2
   dmac_mul_unit u_mul_two (
      .data(mem_data.c_data_bus),
      .coef(mem_data.second_b_data_bus),
      .uns_data(state_q.ins.uns_data),
      .uns_coef(state_q.ins.uns_coef),
      .fractional_mode_bit(state_q.ctrl.fractional_mode_bit),
      .saturate_on_multiply_bit(state_q.ctrl.saturate_on_multiply_bit),
      .product(prod_y),
      .mul_sat(sat_y)
   );

   // low pair from d and b
   dmac_mul_unit u_mul_one (
      .data(mem_data.d_data_bus),
      .coef(mem_data.b_data_bus),
      .uns_data(state_q.ins.uns_data),
      .uns_coef(state_q.ins.uns_coef),
      .fractional_mode_bit(state_q.ctrl.fractional_mode_bit),
      .saturate_on_multiply_bit(state_q.ctrl.saturate_on_multiply_bit),
      .product(prod_x),
      .mul_sat(sat_x)
   );

   dmac_acc_lane u_lane_y (
      .src_acc(state_q.acc_y),
      .shift_src(state_q.ins.dbl_shift),
      .product(prod_y),
      .rnd(state_q.ins.rnd),
      .rounding_mode_bit(state_q.ctrl.rounding_mode_bit),
      .forty_bit_eff(forty_bit_eff),
      .saturation_enable_bit(state_q.ctrl.saturation_enable_bit),
      .result(res_y),
      .ovf(ovf_y)
   );

   dmac_acc_lane u_lane_x (
      .src_acc(state_q.acc_x),
      .shift_src(1'b1),
      .product(prod_x),
      .rnd(state_q.ins.rnd),
      .rounding_mode_bit(state_q.ctrl.rounding_mode_bit),
      .forty_bit_eff(forty_bit_eff),
      .saturation_enable_bit(state_q.ctrl.saturation_enable_bit),
      .result(res_x),
      .ovf(ovf_x)
   );

   // Register read mux
   always_comb begin
      rd_mux = '0;
      map_hit = 1'b1;
      case (paddr)
         OFS_CTRL: begin
            rd_mux[CTRL_FRAC] = state_q.ctrl.fractional_mode_bit;
            rd_mux[CTRL_MSAT] = state_q.ctrl.saturate_on_multiply_bit;
            rd_mux[CTRL_RMODE] = state_q.ctrl.rounding_mode_bit;
            rd_mux[CTRL_SATEN] = state_q.ctrl.saturation_enable_bit;
            rd_mux[CTRL_WIDE] = state_q.ctrl.forty_bit_computation_bit;
         end
         OFS_STATUS: rd_mux[2:0] = state_q.status;
         OFS_MASK: rd_mux[2:0] = state_q.mask;
         OFS_ACCX_LO: rd_mux = state_q.acc_x[31:0];
         OFS_ACCX_HI: rd_mux[7:0] = state_q.acc_x[ACC_W-1:32];
         OFS_ACCY_LO: rd_mux = state_q.acc_y[31:0];
         OFS_ACCY_HI: rd_mux[7:0] = state_q.acc_y[ACC_W-1:32];
         OFS_AUX: rd_mux[ADDR_W-1:0] = state_q.aux;
         OFS_COEF: rd_mux[ADDR_W-1:0] = state_q.coef;
         // Busy flag and cycles left in the repeat
         OFS_BUSY: begin
            rd_mux[0] = exec;
            rd_mux[8 +: RPT_W] = state_q.rpt;
         end
         default: map_hit = 1'b0;
      endcase
   end

   // Next-state logic for everything
   always_comb begin
      state_d = state_q;
      state_d.done = 1'b0;
      // Read data is latched in setup so it is a flop in access
      if (apb_setup) begin
         state_d.rdata = rd_mux;
         state_d.slverr = ~map_hit;
      end
      // Software writes
      if (apb_wr) begin
         case (paddr)
            OFS_CTRL: begin
               state_d.ctrl.fractional_mode_bit = pwdata[CTRL_FRAC];
               state_d.ctrl.saturate_on_multiply_bit = pwdata[CTRL_MSAT];
               state_d.ctrl.rounding_mode_bit = pwdata[CTRL_RMODE];
               state_d.ctrl.saturation_enable_bit = pwdata[CTRL_SATEN];
               state_d.ctrl.forty_bit_computation_bit = pwdata[CTRL_WIDE];
            end
            // Write one to clear
            OFS_STATUS: state_d.status = state_q.status & ~pwdata[2:0];
            OFS_MASK: state_d.mask = pwdata[2:0];
            default: begin
               // Operand state may only change while idle
               if (idle) begin
                  case (paddr)
                     OFS_ACCX_LO: state_d.acc_x[31:0] = pwdata;
                     OFS_ACCX_HI: state_d.acc_x[ACC_W-1:32] = pwdata[7:0];
                     OFS_ACCY_LO: state_d.acc_y[31:0] = pwdata;
                     OFS_ACCY_HI: state_d.acc_y[ACC_W-1:32] = pwdata[7:0];
                     OFS_AUX: state_d.aux = pwdata[ADDR_W-1:0];
                     OFS_COEF: state_d.coef = pwdata[ADDR_W-1:0];
                     default: state_d.aux = state_q.aux;
                  endcase
               end
            end
         endcase
      end
      // Sequencer
      case (state_q.fsm)
         DMAC_IDLE: begin
            if (issue_valid) begin
               state_d.ins = issue;
               state_d.rpt = issue.repeat_cnt;
               state_d.fsm = DMAC_EXEC;
            end
         end
         DMAC_EXEC: begin
            state_d.acc_y = res_y;
            state_d.acc_x = res_x;
            if (ovf_x) begin
               state_d.status[ST_OVX] = 1'b1;
            end
            if (ovf_y) begin
               state_d.status[ST_OVY] = 1'b1;
            end
            if (state_q.ins.aux_dec) begin
               state_d.aux = state_q.aux - PTR_STEP;
            end
            if (state_q.ins.coef_inc) begin
               state_d.coef = state_q.coef + PTR_STEP;
            end
            if (state_q.rpt == '0) begin
               state_d.fsm = DMAC_IDLE;
               state_d.done = 1'b1;
               state_d.status[ST_DONE] = 1'b1;
            end else begin
               state_d.rpt = state_q.rpt - 1'b1;
            end
         end
         default: state_d.fsm = DMAC_IDLE;
      endcase
      // Synchronous reset
      if (sys_rst) begin
         state_d = '0;
         state_d.fsm = DMAC_IDLE;
         state_d.ctrl = CTRL_RST;
         state_d.mask = MASK_RST;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      state_q <= state_d;
   end

   // Outputs
   assign prdata = state_q.rdata;
   assign pslverr = state_q.slverr & psel & penable;
   assign pready = 1'b1; // Zero wait states
   assign issue_ready = idle;
   assign done = state_q.done;
   assign irq = |(state_q.status & state_q.mask);

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_pair_one_cycle: assert property (
      (exec && state_q.rpt == '0) |=> (idle && done))
      else $error("pair did not retire in one cycle");

   a_hi_at_ea: assert property (
      exec |-> (mem_addr.data_hi == state_q.aux
         && mem_addr.coef_hi == state_q.coef && mem_addr.rd))
      else $error("high half not at effective address");

   a_lo_partner: assert property (
      exec |-> (mem_addr.data_lo[0] != mem_addr.data_hi[0]
         && (mem_addr.data_lo >> 1) == (mem_addr.data_hi >> 1)))
      else $error("low half not at partner address");

   a_saturate_on_multiply_bit_clamp: assert property (
      (exec && state_q.ctrl.saturate_on_multiply_bit && state_q.ctrl.fractional_mode_bit
         && !state_q.ins.uns_data && !state_q.ins.uns_coef
         && mem_data.c_data_bus == MIN_Q15
         && mem_data.second_b_data_bus == MIN_Q15)
      |-> (sat_y && prod_y == PROD_MAX))
      else $error("product not clamped");

   a_y_unshifted: assert property (
      (exec && !state_q.ins.dbl_shift && !state_q.ins.rnd && !ovf_y)
      |=> (state_q.acc_y == $past(state_q.acc_y)
         + {{(ACC_W-PROD_W){$past(prod_y[PROD_W-1])}}, $past(prod_y)}))
      else $error("y sum not from unshifted source");

   a_x_shifted: assert property (
      (exec && !state_q.ins.rnd && !ovf_x)
      |=> (state_q.acc_x == {{SHIFT_AMT{$past(state_q.acc_x[ACC_W-1])}},
         $past(state_q.acc_x[ACC_W-1:SHIFT_AMT])}
         + {{(ACC_W-PROD_W){$past(prod_x[PROD_W-1])}}, $past(prod_x)}))
      else $error("x source not shifted by 16");

   a_ovf_flag_set: assert property (
      (exec && ovf_y) |=> state_q.status[ST_OVY])
      else $error("y overflow flag not set");

   a_sat_limits: assert property (
      (exec && ovf_y && state_q.ctrl.saturation_enable_bit && !forty_bit_eff)
      |=> (state_q.acc_y == SAT32_POS || state_q.acc_y == SAT32_NEG))
      else $error("y not saturated at 32 bits");

   a_m40_local: assert property (
      (exec && state_q.ins.forty_bit_kw && !apb_wr)
      |=> $stable(state_q.ctrl.forty_bit_computation_bit))
      else $error("stored forty-bit mode changed");

   a_repeat_count: assert property (
      (idle && issue_valid && issue.repeat_cnt == 8'h02)
      |=> exec [*3] ##1 idle)
      else $error("repeat length wrong");

   a_aux_step: assert property (
      (exec && state_q.ins.aux_dec)
      |=> (state_q.aux == $past(state_q.aux) - PTR_STEP))
      else $error("pointer did not step by two");

endmodule : dmac_top
`default_nettype wire

// File: dmac_top_bench.sv
// Self-checking bench for the dual MAC datapath
`timescale 1ns/1ps
`default_nettype none
module dmac_top_bench
   import dmac_pkg::*;
;
   // One table row: modes, keywords, accumulators, operand halves
   typedef struct packed {
      logic [4:0] ct;
      logic dbl, ud, uc, rnd, kw;
      logic [39:0] ax, ay;
      logic [15:0] dh, dl, ch, cl;
   } dmac_row_s;
   localparam dmac_row_s ROWS [9] = '{
      '{5'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 40'h0000008000, 40'h0000008000,
        16'hff00, 16'hfe00, 16'h8000, 16'h4000},
      '{5'h01, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 40'hff12345678, 40'h0087654321,
        16'h8001, 16'h1234, 16'h7fff, 16'hfedc},
      '{5'h08, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 40'h0, 40'h007fffff00,
        16'h7fff, 16'h0001, 16'h7fff, 16'h0002},
      '{5'h08, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 40'h0, 40'h007fffff00,
        16'h7fff, 16'h0001, 16'h7fff, 16'h0002},
      '{5'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 40'h0000018000, 40'h0000028000,
        16'h0000, 16'h0001, 16'h0000, 16'h8000},
      '{5'h04, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 40'h0000018000, 40'h0000028000,
        16'h0000, 16'h0001, 16'h0000, 16'h8000},
      '{5'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 40'h0, 40'h0,
        16'h8000, 16'h8000, 16'h8000, 16'h8000},
      '{5'h18, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 40'h8000000000, 40'h7fffffff00,
        16'h7fff, 16'h8000, 16'h7fff, 16'h7fff},
      '{5'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 40'h0, 40'h007fffffff,
        16'h0001, 16'h0000, 16'h0001, 16'h0000}};
   localparam logic [7:0] RST_OFS [5] = '{OFS_CTRL, OFS_STATUS, OFS_MASK, OFS_ACCX_LO, OFS_AUX};

   logic sys_clk = 1'b0, sys_rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, errv, issue_ready, done, irq;
   logic issue_valid = 1'b0;
   dmac_issue_s issue = '0;
   dmac_addr_s mem_addr, cap;
   dmac_data_s mem_data;
   int failures = 0, check_count = 0;

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   dmac_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
      .mem_addr(mem_addr), .mem_data(mem_data), .done(done), .irq(irq));
   dmac_mem i_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_data(mem_data));

   // Compare and count
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Ends once pready is seen high; the watchdog covers a hang
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Issue one instruction, time it, capture first operand addresses
   task automatic run(input dmac_issue_s ins);
      int k, rc;
      @(posedge sys_clk);
      issue <= ins;
      issue_valid <= 1'b1;
      @(negedge sys_clk);
      while (issue_ready !== 1'b1) begin
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      k = 0;
      rc = 0;
      do begin
         @(negedge sys_clk);
         k++;
         if (mem_addr.rd === 1'b1) begin
            if (rc == 0) cap = mem_addr;
            rc++;
         end
      end while (done !== 1'b1 && k < 300);
      chk(k, ins.repeat_cnt + 2);
      chk(rc, ins.repeat_cnt + 1);
   endtask : run

   // Reference lane: returns overflow flag above the 40-bit result
   function automatic logic [40:0] lane(input logic [39:0] acc, input logic sh,
      input logic [15:0] d, input logic [15:0] c, input logic ud, input logic uc,
      input logic [4:0] ct, input logic rnd, input logic kw);
      logic signed [33:0] p;
      logic [31:0] p32;
      logic [39:0] src;
      logic [40:0] s;
      logic wide, ov;
      p = $signed({ud ? 1'b0 : d[15], d}) * $signed({uc ? 1'b0 : c[15], c});
      if (ct[CTRL_FRAC]) p = p <<< 1;
      p32 = p[31:0];
      if (ct[CTRL_MSAT] && ct[CTRL_FRAC] && !ud && !uc && d == MIN_Q15 && c == MIN_Q15)
         p32 = PROD_MAX;
      src = sh ? {{16{acc[39]}}, acc[39:16]} : acc;
      s = {src[39], src} + {{9{p32[31]}}, p32};
      if (rnd) begin
         if (!ct[CTRL_RMODE]) s = s + RND_ADD;
         else if (s[15:0] > RND_HALF || (s[15:0] == RND_HALF && s[16])) s = s + 41'h10000;
         s[15:0] = 16'h0;
      end
      wide = ct[CTRL_WIDE] | kw;
      ov = wide ? (s[40] != s[39]) : !(s[40:31] == 10'h0 || s[40:31] == 10'h3ff);
      if (ov && ct[CTRL_SATEN]) begin
         if (wide) return {1'b1, s[40] ? SAT40_NEG : SAT40_POS};
         return {1'b1, s[40] ? SAT32_NEG : SAT32_POS};
      end
      return {ov, s[39:0]};
   endfunction : lane

   // Verdict and end of run
   task automatic results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      results();
   end

   initial begin
      dmac_row_s r;
      dmac_issue_s ins;
      logic [40:0] ex, ey;
      logic [7:0] a;
      for (int j = 0; j < 256; j++) begin
         i_mem.dmem[j] = 16'(j * 613);
         i_mem.cmem[j] = 16'(j * 977 + 5);
      end
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      foreach (RST_OFS[j]) begin
         apb(RST_OFS[j], 1'b0, 32'h0);
         chk(rdv, 32'h0);
      end
      // Table of single-pair cases, alternating pointer parity
      for (int i = 0; i < 9; i++) begin
         r = ROWS[i];
         a = 8'(8'h40 + i);
         i_mem.dmem[a] = r.dh;
         i_mem.dmem[a ^ 8'h01] = r.dl;
         i_mem.cmem[a] = r.ch;
         i_mem.cmem[a ^ 8'h01] = r.cl;
         apb(OFS_CTRL, 1'b1, {27'h0, r.ct});
         apb(OFS_ACCX_LO, 1'b1, r.ax[31:0]);
         apb(OFS_ACCX_HI, 1'b1, {24'h0, r.ax[39:32]});
         apb(OFS_ACCY_LO, 1'b1, r.ay[31:0]);
         apb(OFS_ACCY_HI, 1'b1, {24'h0, r.ay[39:32]});
         apb(OFS_AUX, 1'b1, {24'h0, a});
         apb(OFS_COEF, 1'b1, {24'h0, a});
         ins = '0;
         ins.dbl_shift = r.dbl;
         ins.uns_data = r.ud;
         ins.uns_coef = r.uc;
         ins.rnd = r.rnd;
         ins.forty_bit_kw = r.kw;
         run(ins);
         chk(cap.data_hi, a);
         chk(cap.coef_lo, a ^ 8'h01);
         ex = lane(r.ax, 1'b1, r.dl, r.cl, r.ud, r.uc, r.ct, r.rnd, r.kw);
         ey = lane(r.ay, r.dbl, r.dh, r.ch, r.ud, r.uc, r.ct, r.rnd, r.kw);
         apb(OFS_ACCX_LO, 1'b0, 32'h0);
         chk(rdv, ex[31:0]);
         apb(OFS_ACCX_HI, 1'b0, 32'h0);
         chk(rdv, ex[39:32]);
         apb(OFS_ACCY_LO, 1'b0, 32'h0);
         chk(rdv, ey[31:0]);
         apb(OFS_ACCY_HI, 1'b0, 32'h0);
         chk(rdv, ey[39:32]);
         apb(OFS_STATUS, 1'b0, 32'h0);
         chk(rdv, {29'h0, 1'b1, ey[40], ex[40]});
         apb(OFS_CTRL, 1'b0, 32'h0);
         chk(rdv, r.ct);
         apb(OFS_STATUS, 1'b1, 32'h7);
      end
      // Repeated double-shift run with stepping pointers, done unmasked
      apb(OFS_CTRL, 1'b1, 32'h0);
      apb(OFS_MASK, 1'b1, 32'h4);
      apb(OFS_AUX, 1'b1, 32'h91);
      apb(OFS_COEF, 1'b1, 32'ha0);
      // The table leaves y non-zero; start both sums from zero
      apb(OFS_ACCX_LO, 1'b1, 32'h0);
      apb(OFS_ACCY_LO, 1'b1, 32'h0);
      ins = '0;
      ins.dbl_shift = 1'b1;
      ins.aux_dec = 1'b1;
      ins.coef_inc = 1'b1;
      ins.repeat_cnt = 8'h02;
      run(ins);
      ex = '0;
      ey = '0;
      for (int k = 0; k < 3; k++) begin
         ex = lane(ex[39:0], 1'b1, i_mem.dmem[8'h90 - 2 * k], i_mem.cmem[8'ha1 + 2 * k],
            1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
         ey = lane(ey[39:0], 1'b1, i_mem.dmem[8'h91 - 2 * k], i_mem.cmem[8'ha0 + 2 * k],
            1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
      end
      apb(OFS_ACCX_LO, 1'b0, 32'h0);
      chk(rdv, ex[31:0]);
      apb(OFS_ACCY_LO, 1'b0, 32'h0);
      chk(rdv, ey[31:0]);
      apb(OFS_AUX, 1'b0, 32'h0);
      chk(rdv, 32'h8b);
      apb(OFS_COEF, 1'b0, 32'h0);
      chk(rdv, 32'ha6);
      @(negedge sys_clk);
      chk(irq, 1'b1);
      // Masking and write-one-to-clear of the interrupt
      apb(OFS_MASK, 1'b1, 32'h0);
      @(negedge sys_clk);
      chk(irq, 1'b0);
      apb(OFS_MASK, 1'b1, 32'h4);
      @(negedge sys_clk);
      chk(irq, 1'b1);
      apb(OFS_STATUS, 1'b1, 32'h4);
      @(negedge sys_clk);
      chk(irq, 1'b0);
      // Unmapped word answers with an error and zero
      apb(8'h3c, 1'b0, 32'h0);
      chk(errv, 1'b1);
      chk(rdv, 32'h0);
      // Idle busy word, then a reset while idle clears the mask
      apb(OFS_BUSY, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(OFS_MASK, 1'b0, 32'h0);
      chk(rdv, 32'h0);
      results();
   end
endmodule : dmac_top_bench
`default_nettype wire

// File: dmac_units.sv
// Multiplier unit and accumulate lane of the dual MAC
`timescale 1ns/1ps
`default_nettype none
module dmac_mul_unit
   import dmac_pkg::*;
(
   input wire logic [DATA_W-1:0] data,
   input wire logic [DATA_W-1:0] coef,
   input wire logic uns_data,
   input wire logic uns_coef,
   input wire logic fractional_mode_bit,
   input wire logic saturate_on_multiply_bit,
   output logic [PROD_W-1:0] product,
   output logic mul_sat
);
   logic signed [EXT_W-1:0] ext_d; // Extended data operand
   logic signed [EXT_W-1:0] ext_c; // Extended coefficient
   logic signed [2*EXT_W-1:0] full; // Raw 34-bit product
   logic [2*EXT_W-1:0] scaled; // After fractional shift
   // Extend, multiply, scale, clamp
   always_comb begin
      ext_d = uns_data ? {1'b0, data} : {data[DATA_W-1], data};
      ext_c = uns_coef ? {1'b0, coef} : {coef[DATA_W-1], coef};
      full = ext_d * ext_c;
      scaled = fractional_mode_bit ? {full[2*EXT_W-2:0], 1'b0} : full;
      mul_sat = saturate_on_multiply_bit & fractional_mode_bit & ~uns_data & ~uns_coef
         & (data == MIN_Q15) & (coef == MIN_Q15);
      // Only the low 32 bits travel on; wrap is intended
      product = mul_sat ? PROD_MAX : scaled[PROD_W-1:0];
   end
endmodule : dmac_mul_unit

module dmac_acc_lane
   import dmac_pkg::*;
(
   input wire logic [ACC_W-1:0] src_acc,
   input wire logic shift_src,
   input wire logic [PROD_W-1:0] product,
   input wire logic rnd,
   input wire logic rounding_mode_bit,
   input wire logic forty_bit_eff,
   input wire logic saturation_enable_bit,
   output logic [ACC_W-1:0] result,
   output logic ovf
);
   logic [ACC_W-1:0] shifted; // Source after optional shift
   logic [ACC_W:0] pre_sum; // One guard bit above 40
   logic [ACC_W:0] sum; // After rounding
   logic inc; // Rounding increment wanted
   // Shift, add, round, detect, saturate
   always_comb begin
      shifted = shift_src
         ? {{SHIFT_AMT{src_acc[ACC_W-1]}}, src_acc[ACC_W-1:SHIFT_AMT]}
         : src_acc;
      pre_sum = {shifted[ACC_W-1], shifted}
         + {{(ACC_W+1-PROD_W){product[PROD_W-1]}}, product};
      // mode 0 up, mode 1 to even
      inc = rnd & ~(rounding_mode_bit & (pre_sum[RND_BITS-1:0] == RND_HALF)
         & ~pre_sum[RND_BITS]);
      sum = inc ? pre_sum + RND_ADD : pre_sum;
      if (rnd) begin
         sum[RND_BITS-1:0] = '0;
      end
      if (forty_bit_eff) begin
         ovf = sum[ACC_W] ^ sum[ACC_W-1];
      end else begin
         ovf = ~((&sum[ACC_W:PROD_W-1]) | ~(|sum[ACC_W:PROD_W-1]));
      end
      if (ovf && saturation_enable_bit) begin
         if (forty_bit_eff) begin
            result = sum[ACC_W] ? SAT40_NEG : SAT40_POS;
         end else begin
            result = sum[ACC_W] ? SAT32_NEG : SAT32_POS;
         end
      end else begin
         result = sum[ACC_W-1:0];
      end
   end
endmodule : dmac_acc_lane
`default_nettype wire
